// File: bench/radio_config_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "radio_config_regs.svh"

module radio_config_sequencer_tb import radio_config_pkg::*;;
   localparam logic [16:0] L_A2 = 17'h28;
   localparam logic [16:0] L_N2 = 17'h14;
   localparam logic [16:0] L_A1 = 17'h2C;
   localparam logic [16:0] L_N1 = 17'h16;
   logic clk;
   logic rst;
   logic ce;
   logic [3:0] m_rx;
   logic [3:0] m_pre;
   wire sck;
   wire csn_n;
   wire mosi;
   wire miso;
   wire miso_oe;
   wire sleep;
   wire launch;
   wire busy;
   wire carrier;
   int err_count;
   int num_checks;
   logic [7:0] wbuf [8];
   logic [7:0] rbuf [8];
   logic [55:0] rfv [4];

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   radio_config_sequencer #(.EXCH_ACK_2M_CYC(L_A2), .EXCH_NOACK_2M_CYC(L_N2),
      .EXCH_ACK_1M_CYC(L_A1), .EXCH_NOACK_1M_CYC(L_N1)) uut (
      .CLK_I(clk), .SYS_RST_I(rst), .SCK_I(sck), .SERIAL_SELECT_N_I(csn_n),
      .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(miso_oe), .CHIP_ENABLE_I(ce),
      .METER_RX_I(m_rx), .METER_PRE_I(m_pre), .SLEEP_O(sleep), .TX_LAUNCH_O(launch),
      .EXCHANGE_BUSY_O(busy), .CARRIER_TEST_O(carrier));

   spi_host_model host (.sck_o(sck), .serial_select_n_o(csn_n), .mosi_o(mosi),
      .miso_i(miso), .miso_oe_i(miso_oe));

   ////////////////////////////////////////////////////////////////
   // checking and helpers
   task automatic complete_run();
      if (err_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [7:0] strength_exp(input logic [7:0] ctl, input logic [3:0] pre,
      input logic [3:0] rx);
      return (ctl[`METER_ON_BIT] && ctl[`METER_PICK_BIT] && !ctl[`OUT_PICK_BIT]) ?
         {pre, rx} : 8'h00;
   endfunction : strength_exp

   function automatic logic [7:0] exch_exp(input logic ack, input logic r2);
      return r2 ? (ack ? 8'(L_A2) : 8'(L_N2)) : (ack ? 8'(L_A1) : 8'(L_N1));
   endfunction : exch_exp

   function automatic logic pick(input int s);
      case (s)
         0: return launch;
         1: return busy;
         default: return carrier;
      endcase
   endfunction : pick

   task automatic wait_lvl(input int s, input logic v, input int lim, output int c);
      c = 0;
      while (pick(s) !== v) begin
         @(negedge clk);
         c++;
         if (c > lim) begin
            err_count++;
            complete_run();
         end
      end
   endtask : wait_lvl

   task automatic frame(input logic [7:0] cmd, input int n);
      logic [7:0] st;
      host.begin_frame();
      chk(8'(miso_oe), 8'h01);
      host.xfer(cmd, st);
      for (int k = 0; k < n; k++) host.xfer(wbuf[k], rbuf[k]);
      host.end_frame();
      chk(8'(miso_oe), 8'h00);
   endtask : frame

   task automatic wr1(input logic [4:0] a, input logic [7:0] v);
      wbuf[0] = v;
      frame({`CMD_WRITE, a}, 1);
   endtask : wr1

   task automatic rd(input logic [4:0] a, input int n);
      frame({`CMD_READ, a}, n);
   endtask : rd

   task automatic wide(input logic [4:0] a, input int n, input logic [55:0] vec);
      for (int k = 0; k < n; k++) wbuf[k] = vec[8 * (n - 1 - k) +: 8];
      frame({`CMD_WRITE, a}, n);
      rd(a, n + 1);
      for (int k = 0; k < n; k++) chk(rbuf[k], vec[8 * (n - 1 - k) +: 8]);
      chk(rbuf[n], 8'h00);
   endtask : wide

   task automatic ce_pulse_start();
      @(posedge clk);
      ce <= 1'b1;
   endtask : ce_pulse_start

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int c;
      logic [7:0] v;
      logic seen;
      logic [4:0] singles [3];
      err_count = 0;
      num_checks = 0;
      rst = 1'b1;
      ce = 1'b0;
      m_rx = 4'h0;
      m_pre = 4'h0;
      foreach (wbuf[k]) wbuf[k] = 8'h00;
      singles = '{`OFS_CHANNEL_SELECT, `OFS_RETRY_SETUP, `OFS_RF_POWER_RATE};
      rfv = '{56'hC99AB079BBAB9C, 56'hDA9AB079BBAB9C, 56'hC982B0E1BBAB9C, 56'hDA82B0E3BB839C};
      void'($urandom(3));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(negedge clk);
      chk(8'(sleep), 8'h01);
      rd(`OFS_ADDRESS_LENGTH, 1);
      chk(rbuf[0], `RST_ADDRESS_LENGTH);
      rd(`OFS_RADIO_CONTROL, 1);
      chk(rbuf[0], `RST_RADIO_CONTROL);
      wr1(`OFS_RADIO_CONTROL, 8'h02);
      chk(8'(sleep), 8'h00);
      foreach (singles[i]) begin
         v = 8'($urandom);
         wr1(singles[i], v);
         rd(singles[i], 2);
         chk(rbuf[0], v);
         chk(rbuf[1], 8'h00);
      end
      rd(5'h02, 1);
      chk(rbuf[0], 8'h00);
      foreach (rfv[i]) wide(`OFS_RADIO_FRONT_TUNING, `RADIO_FRONT_BYTES, rfv[i]);
      wide(`OFS_BASEBAND_TUNING, `WIDE_BYTES, 56'hEA3F7F9C20);
      wide(`OFS_BASEBAND_TUNING, `WIDE_BYTES, 56'hD13F7F9C20);
      wide(`OFS_BASEBAND_TUNING, `WIDE_BYTES, 56'hCD3F7F9C20);
      wide(`OFS_DEMOD_TUNING, `WIDE_BYTES, 56'h0BDFC4A703);
      wide(`OFS_TARGET_ADDRESS, `WIDE_BYTES, 56'({$urandom, $urandom}));
      wr1(`OFS_STRENGTH_OUT, 8'hFF);
      foreach (singles[i]) begin
         v = (i == 0) ? 8'h03 : ((i == 1) ? 8'h07 : 8'h01);
         @(posedge clk);
         m_rx <= 4'($urandom);
         m_pre <= 4'($urandom);
         wr1(`OFS_STRENGTH_CONTROL, v);
         rd(`OFS_STRENGTH_OUT, 1);
         chk(rbuf[0], strength_exp(v, m_pre, m_rx));
      end
      for (int i = 0; i < 4; i++) begin
         wr1(`OFS_AUTO_ACK, {7'h00, i[0]});
         wr1(`OFS_RF_POWER_RATE, i[1] ? 8'h0D : 8'h05);
         wbuf[0] = 8'($urandom);
         frame(`CMD_PAYLOAD, 1);
         ce_pulse_start();
         wait_lvl(0, 1'b1, 10, c);
         wait_lvl(1, 1'b1, 5, c);
         wait_lvl(1, 1'b0, 200, c);
         chk(8'(c), exch_exp(i[0], i[1]));
         @(posedge clk);
         ce <= 1'b0;
         rd(`OFS_LINK_STATUS, 1);
         chk(rbuf[0] & 8'h20, 8'h20);
         wr1(`OFS_LINK_STATUS, 8'h20);
         rd(`OFS_LINK_STATUS, 1);
         chk(rbuf[0] & 8'h20, 8'h00);
      end
      frame(`CMD_PAYLOAD, 1);
      frame(`CMD_FLUSH_TX, 0);
      ce_pulse_start();
      seen = 1'b0;
      repeat (20) @(negedge clk) if (launch !== 1'b0) seen = 1'b1;
      chk(8'(seen), 8'h00);
      @(posedge clk);
      ce <= 1'b0;
      wide(`OFS_DEMOD_TUNING, `WIDE_BYTES, 56'h0BDFC4A783);
      host.carrier_lines(1'b1);
      wait_lvl(2, 1'b1, 20, c);
      chk(8'(carrier), 8'h01);
      host.carrier_lines(1'b0);
      wait_lvl(2, 1'b0, 20, c);
      chk(8'(carrier), 8'h00);
      wr1(`OFS_RADIO_CONTROL, 8'h00);
      chk(8'(sleep), 8'h01);
      complete_run();
   end

   initial begin
      #2000000;
      err_count++;
      complete_run();
   end
endmodule : radio_config_sequencer_tb

`default_nettype wire

// File: bench/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////
// serial host: drives frames, samples the answer line
module spi_host_model (
   output logic sck_o,
   output logic serial_select_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic miso_oe_i
);
   logic miso_hold;
   logic miso_line;

   // released line shows inverse of last value
   always @(miso_i or miso_oe_i) if (miso_oe_i) miso_hold = miso_i;
   assign miso_line = miso_oe_i ? miso_i : ~miso_hold;

   initial begin
      sck_o = 1'b0;
      serial_select_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   task automatic begin_frame();
      serial_select_n_o = 1'b0;
      #62.5;
   endtask : begin_frame

   task automatic end_frame();
      serial_select_n_o = 1'b1;
      #150;
   endtask : end_frame

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_o = tx[i];
         #62.5;
         rx[i] = miso_line;
         sck_o = 1'b1;
         #62.5;
         sck_o = 1'b0;
      end
      mosi_o = ~tx[0];
      #250;
   endtask : xfer

   task automatic carrier_lines(input logic v);
      sck_o = v;
      mosi_o = v;
   endtask : carrier_lines
endmodule : spi_host_model

`default_nettype wire

// File: hw/radio_config_pkg.sv
package radio_config_pkg;
   typedef enum logic [3:0] {
      ST_SLEEP = 4'b0001,
      ST_STANDBY = 4'b0010,
      ST_EXCHANGE = 4'b0100,
      ST_CARRIER = 4'b1000
   } radio_state_t;

   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [6:0] rx_shift;
      logic [7:0] rx_byte;
      logic byte_parity;
      logic [7:0] tx_shift;
   } serial_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic byte_parity;
   } serial_rx_t;

   typedef struct packed {
      logic [7:0] radio_control;
      logic [7:0] auto_ack;
      logic [7:0] address_length;
      logic [7:0] retry_setup;
      logic [7:0] channel_select;
      logic [7:0] rf_power_rate;
      logic [7:0] strength_control;
      logic [39:0] transmit_target_address;
      logic [39:0] demod_tuning;
      logic [39:0] baseband_fsm_tuning;
      logic [55:0] radio_front_tuning;
   } reg_file_t;

   typedef struct packed {
      radio_state_t state;
      logic [2:0] csn_sync;
      logic [2:0] parity_sync;
      logic [2:0] ce_sync;
      logic [1:0] sck_sync;
      logic [1:0] mosi_sync;
      logic [7:0] meter_s1;
      logic [7:0] meter_s2;
      logic expect_parity;
      logic [5:0] byte_idx;
      logic [7:0] command;
      logic [7:0] answer;
      reg_file_t regs;
      logic tx_done;
      logic [5:0] payload_cnt;
      logic [16:0] timer;
      logic launch;
      logic [7:0] strength;
   } core_state_t;
endpackage : radio_config_pkg

// File: hw/radio_config_regs.svh
`ifndef RADIO_CONFIG_REGS_SVH
`define RADIO_CONFIG_REGS_SVH
// register offsets
`define OFS_RADIO_CONTROL 5'h00
`define OFS_AUTO_ACK 5'h01
`define OFS_ADDRESS_LENGTH 5'h03
`define OFS_RETRY_SETUP 5'h04
`define OFS_CHANNEL_SELECT 5'h05
`define OFS_RF_POWER_RATE 5'h06
`define OFS_LINK_STATUS 5'h07
`define OFS_TARGET_ADDRESS 5'h10
`define OFS_DEMOD_TUNING 5'h19
`define OFS_STRENGTH_CONTROL 5'h1A
`define OFS_STRENGTH_OUT 5'h1B
`define OFS_RADIO_FRONT_TUNING 5'h1E
`define OFS_BASEBAND_TUNING 5'h1F
// byte counts of the wide registers
`define WIDE_BYTES 5
`define RADIO_FRONT_BYTES 7
// serial commands
`define CMD_READ 3'h0
`define CMD_WRITE 3'h1
`define CMD_PAYLOAD 8'hA0
`define CMD_FLUSH_TX 8'hE1
// field positions
`define CTRL_PRIM_RX 0
`define CTRL_POWER_UP 1
`define RATE_2M_BIT 3
`define ACK_ENABLE_BIT 0
`define STAT_TX_FULL 0
`define STAT_TX_DONE 5
`define METER_ON_BIT 0
`define METER_PICK_BIT 1
`define OUT_PICK_BIT 2
`define CARRIER_ENABLE_BIT 7
// reset values and limits
`define RST_RADIO_CONTROL 8'h00
`define RST_ADDRESS_LENGTH 8'h03
`define PAYLOAD_MAX 6'h20
// timing
`define CLK_KHZ 40000
`define EXCH_ACK_2M_US 1600
`define EXCH_NOACK_2M_US 800
`define EXCH_ACK_1M_US 1700
`define EXCH_NOACK_1M_US 850
`define US_TO_CYC(us) (((us) * `CLK_KHZ) / 1000)
`endif

// File: hw/radio_config_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "radio_config_regs.svh"

////////////////////////////////////////////////////////////////
// What this block does
// - wakes asleep; every sequence starts there
// - 2M exchange 1.6 or 0.8 ms
// - 1M exchange 1.7 or 0.85 ms
// - meter bits select strength onto output
// - low nibble received, high nibble preamble
// - three tuning registers: five, five, seven bytes
// - four-wire serial slave, clock to 8 MHz
module radio_config_sequencer import radio_config_pkg::*; #(
   parameter logic [16:0] EXCH_ACK_2M_CYC = 17'(`US_TO_CYC(`EXCH_ACK_2M_US)),
   parameter logic [16:0] EXCH_NOACK_2M_CYC = 17'(`US_TO_CYC(`EXCH_NOACK_2M_US)),
   parameter logic [16:0] EXCH_ACK_1M_CYC = 17'(`US_TO_CYC(`EXCH_ACK_1M_US)),
   parameter logic [16:0] EXCH_NOACK_1M_CYC = 17'(`US_TO_CYC(`EXCH_NOACK_1M_US))
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic SCK_I,
   input wire logic SERIAL_SELECT_N_I,
   input wire logic MOSI_I,
   output logic MISO_O,
   output logic MISO_OE_O,
   input wire logic CHIP_ENABLE_I,
   input wire logic [3:0] METER_RX_I,
   input wire logic [3:0] METER_PRE_I,
   output logic SLEEP_O,
   output logic TX_LAUNCH_O,
   output logic EXCHANGE_BUSY_O,
   output logic CARRIER_TEST_O
);
   core_state_t r, n;
   serial_rx_t rx;
   logic evt;
   logic wr_evt;
   logic ce_rise;
   logic meter_en;
   logic carrier_cond;
   logic power_up;
   logic prim_rx;
   logic [16:0] exch_len;
   logic [7:0] status;

   ////////////////////////////////////////////////////////////////
   // serial port on the link clock
   serial_link_port u_port (
      .sck_i(SCK_I),
      .serial_select_n_i(SERIAL_SELECT_N_I),
      .mosi_i(MOSI_I),
      .answer_i(r.answer),
      .rx_o(rx),
      .miso_o(MISO_O),
      .miso_oe_o(MISO_OE_O)
   );

   ////////////////////////////////////////////////////////////////
   // byte selection from wide registers
   function automatic logic [7:0] wide_byte(input logic [55:0] v, input int unsigned nbytes,
                                            input logic [5:0] idx);
      logic [55:0] s;
      s = '0;
      if (idx < nbytes) begin
         s = v >> (8 * (nbytes - 1 - idx));
      end
      return s[7:0];
   endfunction : wide_byte

   function automatic logic [7:0] read_reg(input core_state_t c, input logic [4:0] addr,
                                           input logic [5:0] idx, input logic [7:0] stat);
      logic [55:0] v;
      int unsigned nb;
      v = '0;
      nb = 1;
      case (addr)
         `OFS_RADIO_CONTROL: v = {48'h0, c.regs.radio_control};
         `OFS_AUTO_ACK: v = {48'h0, c.regs.auto_ack};
         `OFS_ADDRESS_LENGTH: v = {48'h0, c.regs.address_length};
         `OFS_RETRY_SETUP: v = {48'h0, c.regs.retry_setup};
         `OFS_CHANNEL_SELECT: v = {48'h0, c.regs.channel_select};
         `OFS_RF_POWER_RATE: v = {48'h0, c.regs.rf_power_rate};
         `OFS_LINK_STATUS: v = {48'h0, stat};
         `OFS_STRENGTH_CONTROL: v = {48'h0, c.regs.strength_control};
         `OFS_STRENGTH_OUT: v = {48'h0, c.strength};
         `OFS_TARGET_ADDRESS: begin
            v = {16'h0, c.regs.transmit_target_address};
            nb = `WIDE_BYTES;
         end
         `OFS_DEMOD_TUNING: begin
            v = {16'h0, c.regs.demod_tuning};
            nb = `WIDE_BYTES;
         end
         `OFS_BASEBAND_TUNING: begin
            v = {16'h0, c.regs.baseband_fsm_tuning};
            nb = `WIDE_BYTES;
         end
         `OFS_RADIO_FRONT_TUNING: begin
            v = c.regs.radio_front_tuning;
            nb = `RADIO_FRONT_BYTES;
         end
         default: nb = 0;
      endcase
      return wide_byte(v, nb, idx);
   endfunction : read_reg

   ////////////////////////////////////////////////////////////////
   // decoded conditions
   assign power_up = r.regs.radio_control[`CTRL_POWER_UP];
   assign prim_rx = r.regs.radio_control[`CTRL_PRIM_RX];
   assign evt = ~r.csn_sync[1] & (r.parity_sync[2] != r.expect_parity);
   assign wr_evt = evt & (r.byte_idx != 6'h00) & (r.command[7:5] == `CMD_WRITE);
   assign ce_rise = r.ce_sync[1] & ~r.ce_sync[2];
   assign meter_en = r.regs.strength_control[`METER_ON_BIT]
                     & r.regs.strength_control[`METER_PICK_BIT]
                     & ~r.regs.strength_control[`OUT_PICK_BIT];
   assign carrier_cond = power_up & ~prim_rx & ~r.ce_sync[1] & r.sck_sync[1]
                         & r.mosi_sync[1] & r.csn_sync[1]
                         & r.regs.demod_tuning[`CARRIER_ENABLE_BIT];
   // exchange length by rate and acknowledgement
   assign exch_len = r.regs.rf_power_rate[`RATE_2M_BIT]
      ? (r.regs.auto_ack[`ACK_ENABLE_BIT] ? EXCH_ACK_2M_CYC : EXCH_NOACK_2M_CYC)
      : (r.regs.auto_ack[`ACK_ENABLE_BIT] ? EXCH_ACK_1M_CYC : EXCH_NOACK_1M_CYC);

   always_comb begin
      status = 8'h00;
      status[`STAT_TX_DONE] = r.tx_done;
      status[`STAT_TX_FULL] = (r.payload_cnt == `PAYLOAD_MAX);
   end

   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      n = r;
      n.csn_sync = {r.csn_sync[1:0], SERIAL_SELECT_N_I};
      n.parity_sync = {r.parity_sync[1:0], rx.byte_parity};
      n.ce_sync = {r.ce_sync[1:0], CHIP_ENABLE_I};
      n.sck_sync = {r.sck_sync[0], SCK_I};
      n.mosi_sync = {r.mosi_sync[0], MOSI_I};
      n.meter_s1 = {METER_PRE_I, METER_RX_I};
      n.meter_s2 = r.meter_s1;
      n.launch = 1'b0;
      n.strength = meter_en ? r.meter_s2 : 8'h00;
      if (r.csn_sync[1]) begin
         n.byte_idx = 6'h00;
         n.expect_parity = 1'b0;
         n.answer = status;
      end else if (evt) begin
         n.expect_parity = ~r.expect_parity;
         if (r.byte_idx != 6'h3F) begin
            n.byte_idx = r.byte_idx + 6'h01;
         end
         if (r.byte_idx == 6'h00) begin
            n.command = rx.data;
            if (rx.data == `CMD_FLUSH_TX) begin
               n.payload_cnt = 6'h00;
            end
            if (rx.data[7:5] == `CMD_READ) begin
               n.answer = read_reg(r, rx.data[4:0], 6'h00, status);
            end else begin
               n.answer = status;
            end
         end else if (r.command[7:5] == `CMD_READ) begin
            n.answer = read_reg(r, r.command[4:0], r.byte_idx, status);
         end else if (r.command == `CMD_PAYLOAD) begin
            if (r.payload_cnt != `PAYLOAD_MAX) begin
               n.payload_cnt = r.payload_cnt + 6'h01;
            end
         end
      end
      if (wr_evt) begin
         case (r.command[4:0])
            `OFS_RADIO_CONTROL: n.regs.radio_control = rx.data;
            `OFS_AUTO_ACK: n.regs.auto_ack = rx.data;
            `OFS_ADDRESS_LENGTH: n.regs.address_length = rx.data;
            `OFS_RETRY_SETUP: n.regs.retry_setup = rx.data;
            `OFS_CHANNEL_SELECT: n.regs.channel_select = rx.data;
            `OFS_RF_POWER_RATE: n.regs.rf_power_rate = rx.data;
            `OFS_STRENGTH_CONTROL: n.regs.strength_control = rx.data;
            `OFS_LINK_STATUS: begin
               if (rx.data[`STAT_TX_DONE]) begin
                  n.tx_done = 1'b0;
               end
            end
            // first byte ends up on top
            `OFS_TARGET_ADDRESS: begin
               n.regs.transmit_target_address = {r.regs.transmit_target_address[31:0], rx.data};
            end
            `OFS_DEMOD_TUNING: n.regs.demod_tuning = {r.regs.demod_tuning[31:0], rx.data};
            `OFS_BASEBAND_TUNING: begin
               n.regs.baseband_fsm_tuning = {r.regs.baseband_fsm_tuning[31:0], rx.data};
            end
            `OFS_RADIO_FRONT_TUNING: begin
               n.regs.radio_front_tuning = {r.regs.radio_front_tuning[47:0], rx.data};
            end
            default: n.regs = r.regs;
         endcase
      end
      case (r.state)
         ST_SLEEP: begin
            if (power_up) begin
               n.state = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (ce_rise && !prim_rx && r.payload_cnt != 6'h00) begin
               n.state = ST_EXCHANGE;
               n.timer = exch_len - 17'h1;
               n.launch = 1'b1;
               n.payload_cnt = 6'h00;
            end else if (carrier_cond) begin
               n.state = ST_CARRIER;
            end
         end
         ST_EXCHANGE: begin
            if (r.timer == 17'h0) begin
               n.state = ST_STANDBY;
               n.tx_done = 1'b1;
            end else begin
               n.timer = r.timer - 17'h1;
            end
         end
         ST_CARRIER: begin
            if (!carrier_cond) begin
               n.state = ST_STANDBY;
            end
         end
         default: n.state = ST_SLEEP;
      endcase
      if (!power_up) begin
         n.state = ST_SLEEP;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         r <= '0;
         r.state <= ST_SLEEP;
         r.csn_sync <= 3'h7;
         r.regs.radio_control <= `RST_RADIO_CONTROL;
         r.regs.address_length <= `RST_ADDRESS_LENGTH;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign SLEEP_O = (r.state == ST_SLEEP);
   assign TX_LAUNCH_O = r.launch;
   assign EXCHANGE_BUSY_O = (r.state == ST_EXCHANGE);
   assign CARRIER_TEST_O = (r.state == ST_CARRIER);

   ////////////////////////////////////////////////////////////////
   // checks
   AST_SLEEP_AT_RESET:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      $fell(SYS_RST_I) |-> SLEEP_O && !EXCHANGE_BUSY_O)
      else $error("not asleep after reset");

   AST_SLEEP_WHEN_OFF:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !power_up |=> SLEEP_O && !CARRIER_TEST_O)
      else $error("awake while powered down");

   AST_LOAD_2M_ACK:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      TX_LAUNCH_O && $past(r.regs.rf_power_rate[`RATE_2M_BIT] && r.regs.auto_ack[0])
      |-> r.timer == EXCH_ACK_2M_CYC - 17'h1)
      else $error("wrong 2M acknowledged length");

   AST_LOAD_1M_NOACK:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      TX_LAUNCH_O && $past(!r.regs.rf_power_rate[`RATE_2M_BIT] && !r.regs.auto_ack[0])
      |-> r.timer == EXCH_NOACK_1M_CYC - 17'h1)
      else $error("wrong 1M plain length");

   AST_EXCHANGE_END:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      EXCHANGE_BUSY_O && r.timer == 17'h0 && power_up
      |=> !EXCHANGE_BUSY_O && status[`STAT_TX_DONE])
      else $error("exchange end not flagged");

   AST_LAUNCH_BUSY:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      TX_LAUNCH_O |-> EXCHANGE_BUSY_O && $past(ce_rise) && r.payload_cnt == 6'h00)
      else $error("launch without busy");

   AST_STRENGTH_NIBBLES:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      $past(meter_en) |-> r.strength == {$past(METER_PRE_I, 3), $past(METER_RX_I, 3)})
      else $error("strength nibbles misplaced");

   AST_STRENGTH_OFF:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !meter_en |=> r.strength == 8'h00)
      else $error("strength shown while disabled");

   AST_FRONT_SHIFT:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      wr_evt && r.command[4:0] == `OFS_RADIO_FRONT_TUNING
      |=> r.regs.radio_front_tuning[7:0] == $past(rx.data)
          && r.regs.radio_front_tuning[55:8] == $past(r.regs.radio_front_tuning[47:0]))
      else $error("radio front byte not shifted in");

   AST_CARRIER_GATE:
   assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      CARRIER_TEST_O |-> $past(r.regs.demod_tuning[`CARRIER_ENABLE_BIT] && r.sck_sync[1]))
      else $error("carrier without demod enable");
endmodule : radio_config_sequencer

`default_nettype wire

// File: hw/serial_link_port.sv
`timescale 1ns/10ps
`default_nettype none

module serial_link_port import radio_config_pkg::*; (
   input wire logic sck_i,
   input wire logic serial_select_n_i,
   input wire logic mosi_i,
   input wire logic [7:0] answer_i,
   output serial_rx_t rx_o,
   output logic miso_o,
   output logic miso_oe_o
);
   serial_state_t r, n;

   ////////////////////////////////////////////////////////////////
   // shift in on rising edges, byte parity flips per byte
   always_comb begin
      n = r;
      n.bit_cnt = r.bit_cnt + 3'h1;
      n.rx_shift = {r.rx_shift[5:0], mosi_i};
      if (r.bit_cnt == 3'h0) begin
         n.tx_shift = {answer_i[6:0], 1'b0};
      end else begin
         n.tx_shift = {r.tx_shift[6:0], 1'b0};
      end
      if (r.bit_cnt == 3'h7) begin
         n.rx_byte = {r.rx_shift, mosi_i};
         n.byte_parity = ~r.byte_parity;
      end
   end

   // frame state cleared while select is high
   always_ff @(posedge sck_i or posedge serial_select_n_i) begin
      if (serial_select_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign miso_o = (r.bit_cnt == 3'h0) ? answer_i[7] : r.tx_shift[7];
   assign miso_oe_o = ~serial_select_n_i;
   assign rx_o = '{data: r.rx_byte, byte_parity: r.byte_parity};
endmodule : serial_link_port

`default_nettype wire
